// [hw/pin_mux_defs.svh]
// Constants for the configurable pin function selector.
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
`define FN_TRISTATE 4'h0
`define FN_DRIVE_HIGH 4'h1
`define FN_DRIVE_LOW 4'h2
`define FN_POWER_ENABLE 4'h3
`define FN_SLEEP 4'h4
`define FN_CLK_FAST 4'h5
`define FN_CLK_MID 4'h6
`define FN_CLK_SLOW 4'h7
`define FN_GPIO 4'h8
`define FN_CHARGER 4'h9
`define FN_CHARGER_N 4'hA
`define FN_WRITE_STROBE 4'hB
`define FN_READ_STROBE 4'hC
`define FN_BUS_SENSE 4'hD
`define FN_FRAME_TOGGLE 4'hE
`define FN_KEEP_AWAKE 4'hF
`define REG_CTRL 4'h0
`define REG_GPIO 4'h1
`define REG_PORT_OUT 4'h2
`define REG_PORT_DIR 4'h3
`define REG_PORT_IN 4'h4
`define REG_PRESCALE 4'h5
`define REG_STATUS 4'h6
`define REG_FUNC 4'h7
`define CTRL_BB_EN 0
`define CTRL_BB_SYNC 1
`define PRESCALE_RESET 16'h0009
`endif

// [hw/pin_mux_pkg.sv]
// Types shared by the configurable pin function selector.
`default_nettype none
package pin_mux_pkg;
  typedef enum logic [1:0] {
    BB_IDLE = 2'b00,
    BB_STROBE = 2'b01,
    BB_HOLD = 2'b11
  } bb_state_t;
endpackage
`default_nettype wire

// [hw/pin_sync.sv]
// Two-flop synchroniser for one pin input.
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else if (en)
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// [hw/config_pin_function_mux.sv]
// Configurable pin function selector with 4-bit bit-bang port.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`include "pin_mux_defs.svh"
`default_nettype none
// Notes on behaviour
// (R1) Selection floats the pin, drives it high, or drives it low.
// (R2) Power enable: low once configured, high during suspend.
// (R3) Sleep indicator: low while suspended, high otherwise.
// (R4) Clock outputs of 24, 12 or 6 MHz, stopped in suspend.
// (R5) General purpose: software sets pin output, direction, reads level.
// (R6) Charger detect: high when dedicated charger seen, low otherwise.
// (R7) Inverted charger detect is open drain, pulls low when asserted.
// (R8) Bit-bang write or read strobe, active low, in both modes.
// (R9) Bus-power sense: pin is input giving bus power presence.
// (R10) Frame toggle inverts pin on each start-of-frame.
// (R11) Keep-awake: low pin blocks suspend entry, even unplugged.
// (R12) Exactly one function applies, chosen by stored configuration.
// (R13) Bit-bang enable turns data lines into a 4-bit port.
// (R14) Asynchronous bit-bang paces output writes with a prescaler timer.
// (R15) Synchronous bit-bang samples pins only when written.
// (R16) Function selection loads from memory at reset, then holds.
// (R17) Frame toggle output is low after reset.
module config_pin_function_mux
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] nvm_config,
  input wire logic usb_configured,
  input wire logic usb_suspend_req,
  input wire logic sof_pulse,
  input wire logic charger_detected,
  input wire logic clk_src_fast,
  input wire logic clk_src_mid,
  input wire logic clk_src_slow,
  input wire logic config_pin_in,
  output logic config_pin_out,
  output logic config_pin_oe,
  input wire logic [3:0] bidir_data_lines_in,
  output logic [3:0] bidir_data_lines_out,
  output logic [3:0] bidir_data_lines_oe,
  output logic bitbang_active,
  output logic usb_suspend,
  output logic bus_power_present,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic pin_s;
  logic [3:0] port_s;
  logic clk_sig_s;
  logic clk_sel_raw;
  pin_sync u_pin_sync (
    .clk(clk), .rstn(rstn), .en(clk_en), .d(config_pin_in), .q(pin_s)
  );
  // Clock sources are sampled at 10 MHz, so the pin shows an aliased
  // copy; a real part would gate the source clock in its own tree.
  pin_sync u_clk_sync (
    .clk(clk), .rstn(rstn), .en(clk_en), .d(clk_sel_raw), .q(clk_sig_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_port_sync
      pin_sync u_sync (
        .clk(clk), .rstn(rstn), .en(clk_en),
        .d(bidir_data_lines_in[gi]), .q(port_s[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Function latch and control registers
  // ****************************************************************
  logic [3:0] func_ff, nxt_func;
  logic loaded_ff, nxt_loaded;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [1:0] gpio_ff, nxt_gpio;
  logic [3:0] port_out_ff, nxt_port_out;
  logic [3:0] port_dir_ff, nxt_port_dir;
  logic [3:0] port_in_ff, nxt_port_in;
  logic [15:0] prescale_ff, nxt_prescale;
  logic [15:0] rdata_ff, nxt_rdata;
  logic pend_ff, nxt_pend;
  logic [3:0] pend_val_ff, nxt_pend_val;
  logic wr_port;

  assign wr_port = reg_wr && (reg_addr == `REG_PORT_OUT);

  always_comb
  begin
    nxt_func = func_ff;
    nxt_loaded = 1'b1;
    if (!loaded_ff)
      nxt_func = nvm_config; // R16 R12
    nxt_ctrl = ctrl_ff;
    nxt_gpio = gpio_ff;
    nxt_port_dir = port_dir_ff;
    nxt_prescale = prescale_ff;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `REG_CTRL: nxt_ctrl = reg_wdata[1:0];
        `REG_GPIO: nxt_gpio = reg_wdata[1:0]; // R5
        `REG_PORT_DIR: nxt_port_dir = reg_wdata[3:0];
        `REG_PRESCALE: nxt_prescale = reg_wdata;
        default: ;
      endcase
    end
    nxt_rdata = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `REG_CTRL: nxt_rdata = {14'h0000, ctrl_ff};
        `REG_GPIO: nxt_rdata = {13'h0000, pin_s, gpio_ff}; // R5
        `REG_PORT_OUT: nxt_rdata = {12'h000, port_out_ff};
        `REG_PORT_DIR: nxt_rdata = {12'h000, port_dir_ff};
        `REG_PORT_IN: nxt_rdata = {12'h000, port_in_ff};
        `REG_PRESCALE: nxt_rdata = prescale_ff;
        `REG_STATUS: nxt_rdata = {12'h000, pend_ff, bus_power_present,
                                  usb_suspend, usb_configured};
        `REG_FUNC: nxt_rdata = {12'h000, func_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Bit-bang port
  // ****************************************************************
  bb_state_t bb_state_ff, nxt_bb_state;
  logic [15:0] tmr_ff, nxt_tmr;
  logic wr_strobe_n_ff, nxt_wr_strobe_n;
  logic rd_strobe_n_ff, nxt_rd_strobe_n;
  logic bb_en, bb_sync;

  assign bb_en = ctrl_ff[`CTRL_BB_EN];
  assign bb_sync = ctrl_ff[`CTRL_BB_SYNC];

  always_comb
  begin
    nxt_bb_state = bb_state_ff;
    nxt_tmr = tmr_ff;
    nxt_port_out = port_out_ff;
    nxt_port_in = port_in_ff;
    nxt_pend = pend_ff;
    nxt_pend_val = pend_val_ff;
    nxt_wr_strobe_n = 1'b1;
    nxt_rd_strobe_n = 1'b1;
    if (!bb_en)
    begin
      nxt_bb_state = BB_IDLE;
      nxt_pend = 1'b0;
      if (wr_port)
        nxt_port_out = reg_wdata[3:0];
    end
    else if (bb_sync)
    begin
      nxt_pend = 1'b0;
      if (wr_port)
      begin
        nxt_port_in = port_s; // R15
        nxt_port_out = reg_wdata[3:0];
        nxt_wr_strobe_n = 1'b0; // R8
        nxt_rd_strobe_n = 1'b0; // R8
      end
    end
    else
    begin
      nxt_port_in = port_s;
      if (wr_port)
      begin
        nxt_pend = 1'b1;
        nxt_pend_val = reg_wdata[3:0];
      end
      unique case (bb_state_ff)
        BB_IDLE:
          if (pend_ff)
          begin
            nxt_port_out = pend_val_ff; // R14
            nxt_pend = wr_port;
            nxt_wr_strobe_n = 1'b0; // R8
            nxt_tmr = prescale_ff;
            nxt_bb_state = BB_STROBE;
          end
        BB_STROBE:
        begin
          nxt_rd_strobe_n = 1'b0; // R8
          nxt_bb_state = BB_HOLD;
        end
        BB_HOLD:
          if (tmr_ff == 16'h0000)
            nxt_bb_state = BB_IDLE; // R14
          else
            nxt_tmr = tmr_ff - 16'h0001;
        default: nxt_bb_state = BB_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Suspend, frame toggle and pin selection
  // ****************************************************************
  logic susp_ff, nxt_susp;
  logic cfgd_ff, nxt_cfgd;
  logic toggle_ff, nxt_toggle;
  logic vbus_ff, nxt_vbus;
  logic pin_out_ff, nxt_pin_out;
  logic pin_oe_ff, nxt_pin_oe;
  logic [3:0] port_out_q_ff, nxt_port_out_q;
  logic [3:0] port_oe_q_ff, nxt_port_oe_q;
  logic bb_act_ff, nxt_bb_act;

  always_comb
  begin
    unique case (func_ff)
      `FN_CLK_FAST: clk_sel_raw = clk_src_fast; // R4
      `FN_CLK_MID: clk_sel_raw = clk_src_mid; // R4
      default: clk_sel_raw = clk_src_slow; // R4
    endcase
  end

  always_comb
  begin
    nxt_cfgd = usb_configured && !usb_suspend_req;
    nxt_susp = usb_suspend_req;
    if (func_ff == `FN_KEEP_AWAKE && !pin_s)
      nxt_susp = 1'b0; // R11
    nxt_toggle = toggle_ff ^ sof_pulse; // R10
    nxt_vbus = (func_ff == `FN_BUS_SENSE) ? pin_s : 1'b1; // R9
    nxt_pin_out = 1'b0;
    nxt_pin_oe = 1'b1;
    unique case (func_ff) // R12
      `FN_TRISTATE: nxt_pin_oe = 1'b0; // R1
      `FN_DRIVE_HIGH: nxt_pin_out = 1'b1; // R1
      `FN_DRIVE_LOW: nxt_pin_out = 1'b0; // R1
      `FN_POWER_ENABLE: nxt_pin_out = !cfgd_ff || susp_ff; // R2
      `FN_SLEEP: nxt_pin_out = !susp_ff; // R3
      `FN_CLK_FAST, `FN_CLK_MID, `FN_CLK_SLOW:
        nxt_pin_out = clk_sig_s && !susp_ff; // R4
      `FN_GPIO:
      begin
        nxt_pin_out = gpio_ff[0]; // R5
        nxt_pin_oe = gpio_ff[1]; // R5
      end
      `FN_CHARGER: nxt_pin_out = charger_detected; // R6
      `FN_CHARGER_N: nxt_pin_oe = charger_detected; // R7
      `FN_WRITE_STROBE: nxt_pin_out = wr_strobe_n_ff; // R8
      `FN_READ_STROBE: nxt_pin_out = rd_strobe_n_ff; // R8
      `FN_BUS_SENSE, `FN_KEEP_AWAKE: nxt_pin_oe = 1'b0; // R9 R11
      `FN_FRAME_TOGGLE: nxt_pin_out = toggle_ff; // R10
    endcase
    nxt_bb_act = bb_en; // R13
    nxt_port_out_q = bb_en ? port_out_ff : 4'h0;
    nxt_port_oe_q = bb_en ? port_dir_ff : 4'h0; // R13
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      func_ff <= `FN_TRISTATE;
      loaded_ff <= 1'b0;
      ctrl_ff <= 2'h0;
      gpio_ff <= 2'h0;
      port_out_ff <= 4'h0;
      port_dir_ff <= 4'h0;
      port_in_ff <= 4'h0;
      prescale_ff <= `PRESCALE_RESET;
      rdata_ff <= 16'h0000;
      pend_ff <= 1'b0;
      pend_val_ff <= 4'h0;
      bb_state_ff <= BB_IDLE;
      tmr_ff <= 16'h0000;
      wr_strobe_n_ff <= 1'b1;
      rd_strobe_n_ff <= 1'b1;
      susp_ff <= 1'b0;
      cfgd_ff <= 1'b0;
      toggle_ff <= 1'b0; // R17
      vbus_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      port_out_q_ff <= 4'h0;
      port_oe_q_ff <= 4'h0;
      bb_act_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      func_ff <= nxt_func;
      loaded_ff <= nxt_loaded;
      ctrl_ff <= nxt_ctrl;
      gpio_ff <= nxt_gpio;
      port_out_ff <= nxt_port_out;
      port_dir_ff <= nxt_port_dir;
      port_in_ff <= nxt_port_in;
      prescale_ff <= nxt_prescale;
      rdata_ff <= nxt_rdata;
      pend_ff <= nxt_pend;
      pend_val_ff <= nxt_pend_val;
      bb_state_ff <= nxt_bb_state;
      tmr_ff <= nxt_tmr;
      wr_strobe_n_ff <= nxt_wr_strobe_n;
      rd_strobe_n_ff <= nxt_rd_strobe_n;
      susp_ff <= nxt_susp;
      cfgd_ff <= nxt_cfgd;
      toggle_ff <= nxt_toggle;
      vbus_ff <= nxt_vbus;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      port_out_q_ff <= nxt_port_out_q;
      port_oe_q_ff <= nxt_port_oe_q;
      bb_act_ff <= nxt_bb_act;
    end
  end

  assign config_pin_out = pin_out_ff;
  assign config_pin_oe = pin_oe_ff;
  assign bidir_data_lines_out = port_out_q_ff;
  assign bidir_data_lines_oe = port_oe_q_ff;
  assign bitbang_active = bb_act_ff;
  assign usb_suspend = susp_ff;
  assign bus_power_present = vbus_ff;
  assign reg_rdata = rdata_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tristate;
    @(posedge clk) disable iff (!rstn)
    clk_en && func_ff == `FN_TRISTATE |=> !config_pin_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pin drives"); // R1

  property p_power_en;
    @(posedge clk) disable iff (!rstn)
    clk_en && func_ff == `FN_POWER_ENABLE && susp_ff |=> config_pin_out;
  endproperty
  a_power_en: assert property (p_power_en) else $error("enable low"); // R2

  property p_sleep;
    @(posedge clk) disable iff (!rstn)
    clk_en && func_ff == `FN_SLEEP |=> config_pin_out == !$past(susp_ff);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep level wrong"); // R3

  property p_clk_stop;
    @(posedge clk) disable iff (!rstn)
    clk_en && susp_ff && func_ff inside {[`FN_CLK_FAST:`FN_CLK_SLOW]}
      |=> !config_pin_out;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock running"); // R4

  property p_charger_n;
    @(posedge clk) disable iff (!rstn)
    clk_en && func_ff == `FN_CHARGER_N
      |=> !config_pin_out && config_pin_oe == $past(charger_detected);
  endproperty
  a_charger_n: assert property (p_charger_n) else $error("drain wrong"); // R7

  property p_toggle;
    @(posedge clk) disable iff (!rstn)
    clk_en && sof_pulse |=> toggle_ff != $past(toggle_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no frame toggle"); // R10

  property p_keep_awake;
    @(posedge clk) disable iff (!rstn)
    clk_en && func_ff == `FN_KEEP_AWAKE && !pin_s |=> !usb_suspend;
  endproperty
  a_keep_awake: assert property (p_keep_awake) else $error("suspended"); // R11

  property p_func_hold;
    @(posedge clk) disable iff (!rstn)
    loaded_ff |=> func_ff == $past(func_ff);
  endproperty
  a_func_hold: assert property (p_func_hold) else $error("func moved"); // R16

  property p_sync_sample;
    @(posedge clk) disable iff (!rstn)
    clk_en && bb_en && bb_sync && !wr_port |=> $stable(port_in_ff);
  endproperty
  a_sync_sample: assert property (p_sync_sample) else $error("sampled"); // R15
endmodule
`default_nettype wire

// [testbench/pin_partner.sv]
// Model of the external logic wired to the configurable pin and data lines.
`default_nettype none
module pin_partner (
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic ext_en,
  input wire logic ext_pin,
  input wire logic [3:0] lines_out,
  input wire logic [3:0] lines_oe,
  input wire logic [3:0] ext_lines,
  output logic pin_in,
  output logic [3:0] lines_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Wire resolution.
  // ****************
  // Lines carry pull-ups, so a line nobody drives reads high, never stale.
  assign pin_in = pin_oe ? pin_out : (ext_en ? ext_pin : 1'b1);
  for (genvar i = 0; i < 4; i++)
  begin : g_line
    assign lines_in[i] = lines_oe[i] ? lines_out[i] :
                         (ext_en ? ext_lines[i] : 1'b1);
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking testbench for the configurable pin function selector.
`include "pin_mux_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] nvm_config = 4'h0;
  logic usb_configured = 1'b0, usb_suspend_req = 1'b0;
  logic sof_pulse = 1'b0, charger_detected = 1'b0;
  logic [2:0] src_cnt = 3'h0;
  logic pin_in, pin_out, pin_oe, bitbang_active, usb_suspend;
  logic bus_power_present;
  logic clk_en = 1'b1;
  int edges = 0;
  logic [3:0] lines_in, lines_out, lines_oe, v;
  logic ext_en = 1'b0, ext_pin = 1'b1;
  logic [3:0] ext_lines = 4'h0, reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0, look = 1'b0;
  logic [15:0] rq[$];
  logic [7:0] pq[$];
  logic [7:0] pe;
  int err_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) src_cnt <= src_cnt + 3'h1;
  config_pin_function_mux dut_u (.clk(clk), .rstn(rstn), .clk_en(clk_en),
    .nvm_config(nvm_config), .usb_configured(usb_configured),
    .usb_suspend_req(usb_suspend_req), .sof_pulse(sof_pulse),
    .charger_detected(charger_detected), .clk_src_fast(src_cnt[0]),
    .clk_src_mid(src_cnt[1]), .clk_src_slow(src_cnt[2]),
    .config_pin_in(pin_in), .config_pin_out(pin_out),
    .config_pin_oe(pin_oe), .bidir_data_lines_in(lines_in),
    .bidir_data_lines_out(lines_out), .bidir_data_lines_oe(lines_oe),
    .bitbang_active(bitbang_active), .usb_suspend(usb_suspend),
    .bus_power_present(bus_power_present), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  pin_partner partner_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_pin(ext_pin), .lines_out(lines_out), .lines_oe(lines_oe),
    .ext_lines(ext_lines), .pin_in(pin_in), .lines_in(lines_in));
  // ******************
  // Shared bus tasks.
  // ******************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset(input logic [3:0] f);
    @(posedge clk);
    rstn <= 1'b0;
    nvm_config <= f;
    {usb_configured, usb_suspend_req, charger_detected, ext_en} <= 4'h0;
    tick(6);
    rstn <= 1'b1;
    tick(3);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Mask and expectation cover {oe, out, usb_suspend, bus_power_present}.
  task automatic pin_exp(input logic [3:0] m, input logic [3:0] e);
    @(posedge clk);
    pq.push_back({m, e});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  task automatic bb_wait(input logic [3:0] d);
    int i = 0;
    while (pin_out !== 1'b0 && i < 40)
    begin
      @(posedge clk);
      i++;
    end
    check({3'h0, bitbang_active, lines_oe, lines_out, 3'h0, pin_out},
          {3'h0, 1'b1, 4'hF, d, 4'h0});
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // *****************
  // Result watcher.
  // *****************
  always @(posedge clk)
  begin
    if (rd_pend)
      check(reg_rdata, rq.pop_front());
    if (look)
    begin
      pe = pq.pop_front();
      check({12'h000, pe[7:4] &
             {pin_oe, pin_out, usb_suspend, bus_power_present}},
            {12'h000, pe[3:0]});
    end
    rd_pend <= reg_rd;
  end
  initial
  begin
    tick(5000);
    err_count++;
    test_done;
  end
  // ***********
  // Scenarios.
  // ***********
  initial
  begin
    void'($urandom(33313));
    for (int f = 0; f < 16; f++)
    begin
      do_reset(4'(f));
      rd(`REG_FUNC, 16'(f));
      wr(`REG_FUNC, 16'h0005);
      rd(`REG_FUNC, 16'(f));
      if (f < 3)
        pin_exp(f == 0 ? 4'hB : 4'hF,
                f == 0 ? 4'h1 : (f == 1 ? 4'hD : 4'h9));
    end
    rd(4'hF, 16'h0000);
    do_reset(`FN_POWER_ENABLE);
    pin_exp(4'hC, 4'hC);
    usb_configured <= 1'b1;
    tick(3);
    pin_exp(4'hF, 4'h9);
    usb_suspend_req <= 1'b1;
    tick(3);
    pin_exp(4'hF, 4'hF);
    do_reset(`FN_SLEEP);
    pin_exp(4'hF, 4'hD);
    usb_suspend_req <= 1'b1;
    tick(3);
    pin_exp(4'hF, 4'hB);
    for (int k = 0; k < 2; k++)
    begin
      do_reset(k == 0 ? `FN_CHARGER : `FN_CHARGER_N);
      charger_detected <= 1'b1;
      tick(3);
      pin_exp(4'hF, k == 0 ? 4'hD : 4'h9);
      charger_detected <= 1'b0;
      tick(3);
      pin_exp(k == 0 ? 4'hF : 4'hB, k == 0 ? 4'h9 : 4'h1);
    end
    do_reset(`FN_FRAME_TOGGLE);
    pin_exp(4'hF, 4'h9);
    for (int k = 0; k < 3; k++)
    begin
      sof_pulse <= 1'b1;
      tick(1);
      sof_pulse <= 1'b0;
      tick(2);
      pin_exp(4'hF, k[0] ? 4'h9 : 4'hD);
    end
    clk_en <= 1'b0;
    sof_pulse <= 1'b1;
    tick(2);
    sof_pulse <= 1'b0;
    clk_en <= 1'b1;
    tick(2);
    pin_exp(4'hF, 4'hD);
    do_reset(`FN_BUS_SENSE);
    ext_en <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ext_pin <= k[0];
      tick(5);
      pin_exp(4'h9, {3'h0, k[0]});
    end
    do_reset(`FN_KEEP_AWAKE);
    ext_en <= 1'b1;
    ext_pin <= 1'b0;
    usb_suspend_req <= 1'b1;
    tick(5);
    pin_exp(4'hA, 4'h0);
    ext_pin <= 1'b1;
    tick(5);
    pin_exp(4'hA, 4'h2);
    do_reset(`FN_GPIO);
    wr(`REG_GPIO, 16'h0003);
    pin_exp(4'hC, 4'hC);
    wr(`REG_GPIO, 16'h0002);
    pin_exp(4'hC, 4'h8);
    wr(`REG_GPIO, 16'h0000);
    ext_en <= 1'b1;
    ext_pin <= 1'b0;
    tick(4);
    rd(`REG_GPIO, 16'h0000);
    ext_pin <= 1'b1;
    tick(4);
    rd(`REG_GPIO, 16'h0004);
    for (int f = 11; f < 13; f++)
    begin
      do_reset(4'(f));
      wr(`REG_PRESCALE, 16'h0002);
      wr(`REG_PORT_DIR, 16'h000F);
      wr(`REG_CTRL, 16'h0001);
      repeat (2)
      begin
        v = 4'($urandom);
        wr(`REG_PORT_OUT, {12'h000, v});
        bb_wait(v);
      end
    end
    do_reset(`FN_WRITE_STROBE);
    wr(`REG_CTRL, 16'h0003);
    v = 4'($urandom);
    ext_en <= 1'b1;
    ext_lines <= v;
    tick(4);
    wr(`REG_PORT_OUT, 16'h0000);
    ext_lines <= ~v;
    tick(2);
    check({15'h0000, pin_out}, 16'h0000);
    tick(2);
    rd(`REG_PORT_IN, {12'h000, v});
    for (int f = 5; f < 8; f++)
    begin
      do_reset(4'(f));
      tick(4);
      v[0] = pin_out;
      edges = 0;
      repeat (8)
      begin
        @(posedge clk);
        if (pin_out !== v[0])
          edges++;
        v[0] = pin_out;
      end
      check(16'(edges), 16'(8 >> (f - 5)));
      usb_suspend_req <= 1'b1;
      tick(4);
      repeat (6)
      begin
        @(posedge clk);
        check({15'h0000, pin_out}, 16'h0000);
      end
    end
    tick(4);
    test_done;
  end
endmodule
`default_nettype wire
